// ===== hdl/alr_pkg.sv
package alr_pkg;

   // Register byte offsets
   localparam logic [7:0]  ALR_OFS_CTRL    = 8'h00;
   localparam logic [7:0]  ALR_OFS_TIMING  = 8'h04;
   localparam logic [7:0]  ALR_OFS_REF     = 8'h08;
   localparam logic [7:0]  ALR_OFS_STAT    = 8'h0c;

   // Control field positions
   localparam int          ALR_CTRL_PATH   = 0;
   localparam int          ALR_CTRL_REC_EN = 1;
   localparam int          ALR_CTRL_PLY_EN = 2;
   localparam int          ALR_CTRL_FOFF   = 3;
   localparam int          ALR_CTRL_FATT   = 4;
   localparam int          ALR_CTRL_EQBYP  = 5;

   // Timing field positions
   localparam int          ALR_TIM_WAIT    = 0;
   localparam int          ALR_TIM_STEP    = 4;
   localparam int          ALR_TIM_FAST    = 8;
   localparam int          ALR_TIM_LMTH    = 12;

   // Reference field positions
   localparam int          ALR_REF_REC     = 0;
   localparam int          ALR_REF_PLAY    = 8;

   // Writable bits and reset values
   localparam logic [31:0] ALR_CTRL_MASK   = 32'h0000_003f;
   localparam logic [31:0] ALR_TIM_MASK    = 32'h0000_7373;
   localparam logic [31:0] ALR_REF_MASK    = 32'h0000_3fff;
   localparam logic [31:0] ALR_RST_CTRL    = 32'h0000_0001;
   localparam logic [31:0] ALR_RST_TIMING  = 32'h0000_0000;
   localparam logic [31:0] ALR_RST_REF     = 32'h0000_28e1;

   // Gain in fine units of 0.375/352 dB
   localparam logic signed [17:0] ALR_FU_REC      = 18'sh00160;
   localparam logic signed [17:0] ALR_FU_PLAY     = 18'sh00580;
   localparam logic [7:0]         ALR_REC_ZERO    = 8'h91;
   localparam logic [7:0]         ALR_REC_MUTEMAX = 8'h04;
   localparam logic [5:0]         ALR_PLAY_ZERO   = 6'h24;
   localparam logic [5:0]         ALR_PLAY_MUTE   = 6'h00;

   // Readback quantiser
   localparam logic signed [17:0] ALR_RB_FLOOR_FU = 18'sh10800;
   localparam logic signed [17:0] ALR_GAIN_MIN    = -ALR_RB_FLOOR_FU;
   localparam logic [17:0]        ALR_RB_STEP_FU  = 18'h002c0;
   localparam logic [17:0]        ALR_RB_TOP_IDX  = 18'h00090;
   localparam logic [17:0]        ALR_RB_LOW_IDX  = 18'h00019;
   localparam logic [17:0]        ALR_RB_BIAS     = 18'h00020;
   localparam logic [7:0]         ALR_RB_MAX      = 8'hff;
   localparam logic [7:0]         ALR_RB_LOW      = 8'h10;
   localparam logic [7:0]         ALR_RB_MUTE     = 8'h00;

   // Recovery timing counted in sample ticks, and recovery step sizes in fine units
   localparam logic [10:0] ALR_WAIT_BASE   = 11'h080;
   localparam logic [2:0]  ALR_STEP_COARSE = 3'h4;
   localparam logic [2:0]  ALR_STEP_FINE   = 3'h1;
   localparam logic [2:0]  ALR_STEP_SLOW   = 3'h3;
   localparam logic [5:0]  ALR_IVL_BASE    = 6'h01;
   localparam logic [15:0] ALR_FAST_STEPS  = 16'hc643;
   localparam logic [4:0]  ALR_RATT_IVL0   = 5'h04;
   localparam logic [4:0]  ALR_RATT_IVL1   = 5'h10;

   // Bus responses
   localparam logic [1:0]  ALR_RESP_OKAY   = 2'h0;
   localparam logic [1:0]  ALR_RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      ALR_IDLE,
      ALR_WAIT,
      ALR_RECOVER
   } alr_mode_t;

   function automatic logic [10:0] alr_wait_len(input logic [1:0] sel);
      return ALR_WAIT_BASE << sel;
   endfunction : alr_wait_len

   function automatic logic [2:0] alr_step_fine(input logic [2:0] sel);
      return (sel < ALR_STEP_SLOW) ? (ALR_STEP_COARSE >> sel) : ALR_STEP_FINE;
   endfunction : alr_step_fine

   function automatic logic [5:0] alr_step_ivl(input logic [2:0] sel);
      return (sel < ALR_STEP_SLOW) ? ALR_IVL_BASE : (ALR_IVL_BASE << (sel - 3'h2));
   endfunction : alr_step_ivl

   function automatic logic [3:0] alr_fast_step(input logic [1:0] sel);
      return ALR_FAST_STEPS[{sel, 2'b00} +: 4];
   endfunction : alr_fast_step

endpackage : alr_pkg

// ===== hdl/alr_gain_code.sv
`timescale 1ns/100ps
module alr_gain_code
   import alr_pkg::*;
(
   // Clock and reset
   input  wire logic               clk_i,
   input  wire logic               nrst_i,
   // Working gain
   input  wire logic signed [17:0] gain_i,
   input  wire logic               mute_i,
   input  wire logic               active_i,
   // Coarse code
   output logic [7:0]              code_o
);

   typedef struct packed {
      logic [7:0] code;
   } alr_code_regs_t;

   alr_code_regs_t state_ff;
   alr_code_regs_t nxt_state;
   logic [17:0]    lifted;
   logic [17:0]    idx;

   // Gain never drops below the floor, so the lifted value is never negative
   assign lifted = 18'(gain_i + ALR_RB_FLOOR_FU);
   assign idx    = lifted / ALR_RB_STEP_FU;

   always_comb begin
      nxt_state = state_ff;
      if (active_i) begin
         if (mute_i) begin
            nxt_state.code = ALR_RB_MUTE;
         end else if (idx >= ALR_RB_TOP_IDX) begin
            nxt_state.code = ALR_RB_MAX;
         end else if (idx < ALR_RB_LOW_IDX) begin
            nxt_state.code = ALR_RB_LOW;
         end else begin
            nxt_state.code = 8'((idx << 1) - ALR_RB_BIAS);
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign code_o = state_ff.code;

endmodule : alr_gain_code

// ===== hdl/alr_recovery.sv
// Design decisions made here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/100ps
module alr_recovery
   import alr_pkg::*;
(
   // Clock and reset
   input  wire logic               clk_i,
   input  wire logic               nrst_i,
   // AXI4-Lite slave
   input  wire logic [7:0]         s_axi_awaddr_i,
   input  wire logic               s_axi_awvalid_i,
   output logic                    s_axi_awready_o,
   input  wire logic [31:0]        s_axi_wdata_i,
   input  wire logic [3:0]         s_axi_wstrb_i,
   input  wire logic               s_axi_wvalid_i,
   output logic                    s_axi_wready_o,
   output logic [1:0]              s_axi_bresp_o,
   output logic                    s_axi_bvalid_o,
   input  wire logic               s_axi_bready_i,
   input  wire logic [7:0]         s_axi_araddr_i,
   input  wire logic               s_axi_arvalid_i,
   output logic                    s_axi_arready_o,
   output logic [31:0]             s_axi_rdata_o,
   output logic [1:0]              s_axi_rresp_o,
   output logic                    s_axi_rvalid_o,
   input  wire logic               s_axi_rready_i,
   // Level detection and limiter
   input  wire logic               fs_tick_i,
   input  wire logic               limiter_busy_i,
   input  wire logic               att_pulse_i,
   input  wire logic [9:0]         att_amt_i,
   input  wire logic               out_ge_reset_i,
   input  wire logic               out_ge_limit_i,
   input  wire logic               peak_hi_i,
   input  wire logic               impulse_i,
   // Gain and settings out
   output logic signed [17:0]      working_gain_o,
   output logic                    gain_mute_o,
   output logic [7:0]              gain_readback_o,
   output logic                    recovering_o,
   output logic                    path_select_o,
   output logic [2:0]              limiter_threshold_sel_o,
   output logic                    level_eq_bypass_o
);

   typedef struct packed {
      logic [31:0]        ctrl;
      logic [31:0]        timing;
      logic [31:0]        refl;
      logic               aw_have;
      logic [7:0]         aw_addr;
      logic               w_have;
      logic [31:0]        w_data;
      logic [3:0]         w_strb;
      logic               bvalid;
      logic [1:0]         bresp;
      logic               rvalid;
      logic [31:0]        rdata;
      logic [1:0]         rresp;
      alr_mode_t          mode;
      logic [10:0]        timer;
      logic [6:0]         ivl;
      logic               fast;
      logic [4:0]         ratt;
      logic [17:0]        ref_att;
      logic signed [17:0] gain;
      logic               gain_mute;
   } alr_regs_t;

   localparam alr_regs_t ALR_REGS_RST = '{ctrl: ALR_RST_CTRL, timing: ALR_RST_TIMING,
                                          refl: ALR_RST_REF, mode: ALR_IDLE, default: '0};

   alr_regs_t          state_ff;
   alr_regs_t          nxt_state;
   logic               en;
   logic               fast_off;
   logic [7:0]         rec_code;
   logic [5:0]         play_code;
   logic               ref_mute;
   logic signed [17:0] ref_fine;
   logic signed [17:0] tgt;
   logic signed [18:0] sum;
   logic signed [18:0] diff;
   logic signed [17:0] lowered;
   logic [3:0]         step_amt;
   logic [6:0]         ivl_len;
   logic               fire;
   logic [4:0]         ratt_len;
   logic [7:0]         rb_code;

   function automatic logic [31:0] alr_merge(input logic [31:0] old, input logic [31:0] data,
                                            input logic [3:0] strb, input logic [31:0] mask);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[8*i +: 8] = data[8*i +: 8];
         end
      end
      return res & mask;
   endfunction : alr_merge

   // Settings decode
   assign path_select_o = state_ff.ctrl[ALR_CTRL_PATH];
   assign en = path_select_o ? state_ff.ctrl[ALR_CTRL_REC_EN]
                             : state_ff.ctrl[ALR_CTRL_PLY_EN];
   assign fast_off  = state_ff.ctrl[ALR_CTRL_FOFF];
   assign rec_code  = state_ff.refl[ALR_REF_REC +: 8];
   assign play_code = state_ff.refl[ALR_REF_PLAY +: 6];
   assign ref_mute  = path_select_o ? (rec_code <= ALR_REC_MUTEMAX)
                                    : (play_code == ALR_PLAY_MUTE);
   assign ref_fine  = path_select_o
      ? (($signed({10'h000, rec_code}) - $signed({10'h000, ALR_REC_ZERO})) * ALR_FU_REC)
      : (($signed({12'h000, play_code}) - $signed({12'h000, ALR_PLAY_ZERO})) * ALR_FU_PLAY);
   assign tgt = ref_fine - $signed(state_ff.ref_att);

   // Step and interval
   assign step_amt = state_ff.fast ? alr_fast_step(state_ff.timing[ALR_TIM_FAST +: 2])
                 : {1'b0, alr_step_fine(state_ff.timing[ALR_TIM_STEP +: 3])};
   // Doubling the interval halves the rate above -12 dBFS, cheaper than a second step table
   assign ivl_len = peak_hi_i ? {alr_step_ivl(state_ff.timing[ALR_TIM_STEP +: 3]), 1'b0}
                              : {1'b0, alr_step_ivl(state_ff.timing[ALR_TIM_STEP +: 3])};
   assign fire     = state_ff.fast || (7'(state_ff.ivl + 7'h01) >= ivl_len);
   assign ratt_len = state_ff.ctrl[ALR_CTRL_FATT] ? ALR_RATT_IVL1 : ALR_RATT_IVL0;
   assign sum      = $signed({state_ff.gain[17], state_ff.gain}) + $signed({15'h0000, step_amt});
   assign diff     = $signed({state_ff.gain[17], state_ff.gain}) - $signed({9'h000, att_amt_i});
   assign lowered  = (diff < $signed({ALR_GAIN_MIN[17], ALR_GAIN_MIN})) ? ALR_GAIN_MIN
                                                                          : diff[17:0];

   always_comb begin
      nxt_state = state_ff;
      // Write channel: address and data may arrive in either order
      if (s_axi_awvalid_i && s_axi_awready_o) begin
         nxt_state.aw_have = 1'b1;
         nxt_state.aw_addr = s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
         nxt_state.w_have = 1'b1;
         nxt_state.w_data = s_axi_wdata_i;
         nxt_state.w_strb = s_axi_wstrb_i;
      end
      if (state_ff.bvalid && s_axi_bready_i) begin
         nxt_state.bvalid = 1'b0;
      end
      if (state_ff.aw_have && state_ff.w_have && !state_ff.bvalid) begin
         nxt_state.aw_have = 1'b0;
         nxt_state.w_have  = 1'b0;
         nxt_state.bvalid  = 1'b1;
         nxt_state.bresp   = ALR_RESP_OKAY;
         case (state_ff.aw_addr)
            ALR_OFS_CTRL: begin
               nxt_state.ctrl = alr_merge(state_ff.ctrl, state_ff.w_data, state_ff.w_strb,
                                          ALR_CTRL_MASK);
            end
            ALR_OFS_TIMING: begin
               nxt_state.timing = alr_merge(state_ff.timing, state_ff.w_data, state_ff.w_strb,
                                            ALR_TIM_MASK);
            end
            ALR_OFS_REF: begin
               nxt_state.refl = alr_merge(state_ff.refl, state_ff.w_data, state_ff.w_strb,
                                          ALR_REF_MASK);
            end
            ALR_OFS_STAT: begin
               nxt_state.bresp = ALR_RESP_OKAY;
            end
            default: begin
               nxt_state.bresp = ALR_RESP_SLVERR;
            end
         endcase
      end
      // Read channel
      if (state_ff.rvalid && s_axi_rready_i) begin
         nxt_state.rvalid = 1'b0;
      end
      if (s_axi_arvalid_i && s_axi_arready_o) begin
         nxt_state.rvalid = 1'b1;
         nxt_state.rresp  = ALR_RESP_OKAY;
         nxt_state.rdata  = '0;
         case (s_axi_araddr_i)
            ALR_OFS_CTRL: begin
               nxt_state.rdata = state_ff.ctrl;
            end
            ALR_OFS_TIMING: begin
               nxt_state.rdata = state_ff.timing;
            end
            ALR_OFS_REF: begin
               nxt_state.rdata = state_ff.refl;
            end
            ALR_OFS_STAT: begin
               nxt_state.rdata = {21'h000000, state_ff.fast, 2'(state_ff.mode), rb_code};
            end
            default: begin
               nxt_state.rresp = ALR_RESP_SLVERR;
            end
         endcase
      end
      // Recovery engine
      if (impulse_i && !fast_off) begin
         nxt_state.fast = 1'b1;
      end
      if (fast_off) begin
         nxt_state.fast    = 1'b0;
         nxt_state.ref_att = '0;
      end
      if (!en) begin
         nxt_state.mode      = ALR_IDLE;
         nxt_state.timer     = '0;
         nxt_state.ivl       = '0;
         nxt_state.ratt      = '0;
         nxt_state.fast      = 1'b0;
         nxt_state.ref_att   = '0;
         nxt_state.gain      = ref_fine;
         nxt_state.gain_mute = ref_mute;
      end else if (limiter_busy_i || state_ff.mode == ALR_IDLE) begin
         // Wait restarts from zero once the limiter lets go
         nxt_state.mode  = ALR_WAIT;
         nxt_state.timer = '0;
         nxt_state.ivl   = '0;
         if (att_pulse_i) begin
            nxt_state.gain = lowered;
         end
      end else if (fs_tick_i) begin
         unique case (state_ff.mode)
            ALR_IDLE: begin
               nxt_state.mode = ALR_WAIT;
            end
            ALR_WAIT: begin
               if (out_ge_reset_i) begin
                  nxt_state.timer = '0;
               end else if (state_ff.timer ==
                            11'(alr_wait_len(state_ff.timing[ALR_TIM_WAIT +: 2]) - 11'h001)) begin
                  nxt_state.mode  = ALR_RECOVER;
                  nxt_state.timer = '0;
                  nxt_state.ivl   = '0;
                  nxt_state.ratt  = '0;
               end else begin
                  nxt_state.timer = 11'(state_ff.timer + 11'h001);
               end
            end
            ALR_RECOVER: begin
               if (out_ge_reset_i && !out_ge_limit_i) begin
                  nxt_state.mode  = ALR_WAIT;
                  nxt_state.timer = '0;
               end else begin
                  nxt_state.ivl = fire ? 7'h00 : 7'(state_ff.ivl + 7'h01);
                  if (fire && state_ff.gain < tgt) begin
                     nxt_state.gain = (sum >= $signed({tgt[17], tgt})) ? tgt : sum[17:0];
                  end
                  if (state_ff.fast) begin
                     if (sum >= $signed({tgt[17], tgt})) begin
                        nxt_state.fast    = 1'b0;
                        nxt_state.ref_att = '0;
                        nxt_state.ratt    = '0;
                     end else if (5'(state_ff.ratt + 5'h01) == ratt_len) begin
                        nxt_state.ratt    = '0;
                        nxt_state.ref_att = 18'(state_ff.ref_att + 18'h00001);
                     end else begin
                        nxt_state.ratt = 5'(state_ff.ratt + 5'h01);
                     end
                  end
               end
            end
         endcase
      end
      if (en) begin
         nxt_state.gain_mute = ref_mute;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         state_ff <= ALR_REGS_RST;
      end else begin
         state_ff <= nxt_state;
      end
   end

   alr_gain_code u_gain_code (
      .clk_i    (clk_i),
      .nrst_i   (nrst_i),
      .gain_i   (state_ff.gain),
      .mute_i   (state_ff.gain_mute),
      .active_i (en),
      .code_o   (rb_code)
   );

   assign s_axi_awready_o         = !state_ff.aw_have && !state_ff.bvalid;
   assign s_axi_wready_o          = !state_ff.w_have && !state_ff.bvalid;
   assign s_axi_bvalid_o          = state_ff.bvalid;
   assign s_axi_bresp_o           = state_ff.bresp;
   assign s_axi_arready_o         = !state_ff.rvalid;
   assign s_axi_rvalid_o          = state_ff.rvalid;
   assign s_axi_rdata_o           = state_ff.rdata;
   assign s_axi_rresp_o           = state_ff.rresp;
   assign working_gain_o          = state_ff.gain;
   assign gain_mute_o             = state_ff.gain_mute;
   assign gain_readback_o         = rb_code;
   assign recovering_o            = (state_ff.mode == ALR_RECOVER);
   assign limiter_threshold_sel_o = state_ff.timing[ALR_TIM_LMTH +: 3];
   assign level_eq_bypass_o       = state_ff.ctrl[ALR_CTRL_EQBYP];

   a_wait_restart: assert property (@(posedge clk_i) disable iff (!nrst_i)
      en && limiter_busy_i |=> state_ff.mode == ALR_WAIT && state_ff.timer == 11'h000)
      else $error("wait not restarted by limiter");

   a_wait_done: assert property (@(posedge clk_i) disable iff (!nrst_i)
      en && !limiter_busy_i && fs_tick_i && state_ff.mode == ALR_WAIT && !out_ge_reset_i
      && state_ff.timer == 11'(alr_wait_len(state_ff.timing[ALR_TIM_WAIT +: 2]) - 11'h001)
      |=> recovering_o)
      else $error("recovery did not start after wait");

   a_gain_cap: assert property (@(posedge clk_i) disable iff (!nrst_i)
      en && $stable(ref_fine) && state_ff.gain <= tgt |=> state_ff.gain <= tgt)
      else $error("gain raised past reference");

   a_step_size: assert property (@(posedge clk_i) disable iff (!nrst_i)
      en && recovering_o && fs_tick_i && !limiter_busy_i && !state_ff.fast && !peak_hi_i
      && !(out_ge_reset_i && !out_ge_limit_i) && state_ff.timing[ALR_TIM_STEP +: 3] == 3'h0
      && state_ff.gain < 18'(tgt - 18'sh00004)
      |=> state_ff.gain == 18'($past(state_ff.gain) + 18'sh00004))
      else $error("wrong recovery step");

   a_slow_peak: assert property (@(posedge clk_i) disable iff (!nrst_i)
      en && recovering_o && fs_tick_i && peak_hi_i && !state_ff.fast && !limiter_busy_i
      && state_ff.ivl == 7'h00 |=> $stable(state_ff.gain))
      else $error("recovery not slowed by peak");

   a_timer_clear: assert property (@(posedge clk_i) disable iff (!nrst_i)
      en && recovering_o && fs_tick_i && !limiter_busy_i && out_ge_reset_i && !out_ge_limit_i
      |=> state_ff.mode == ALR_WAIT ##0 state_ff.timer == 11'h000)
      else $error("wait timer not cleared");

   a_timer_run: assert property (@(posedge clk_i) disable iff (!nrst_i)
      en && !limiter_busy_i && fs_tick_i && state_ff.mode == ALR_WAIT && !out_ge_reset_i
      && !recovering_o ##1 state_ff.mode == ALR_WAIT
      |-> state_ff.timer == 11'($past(state_ff.timer) + 11'h001))
      else $error("wait timer not running");

   a_fast_off: assert property (@(posedge clk_i) disable iff (!nrst_i)
      fast_off |=> !state_ff.fast)
      else $error("fast recovery while disabled");

   a_readback_mute: assert property (@(posedge clk_i) disable iff (!nrst_i)
      en && state_ff.gain_mute |=> gain_readback_o == ALR_RB_MUTE)
      else $error("mute not reported");

   a_path_off: assert property (@(posedge clk_i) disable iff (!nrst_i)
      !en |=> state_ff.mode == ALR_IDLE && state_ff.gain == $past(ref_fine) ##1 !recovering_o)
      else $error("recovery while disabled");

endmodule : alr_recovery

// ===== tb/alr_host.sv
`timescale 1ns/100ps
module alr_host (
   // Clock
   input  wire logic        clk_i,
   // Write side
   output logic [7:0]       aw_o,
   output logic             awv_o,
   input  wire logic        awr_i,
   output logic [31:0]      wd_o,
   output logic             wv_o,
   input  wire logic        wr_i,
   input  wire logic [1:0]  br_i,
   input  wire logic        bv_i,
   output logic             bp_o,
   // Read side
   output logic [7:0]       ar_o,
   output logic             arv_o,
   input  wire logic        arr_i,
   input  wire logic [31:0] rd_i,
   input  wire logic [1:0]  rr_i,
   input  wire logic        rv_i,
   output logic             rp_o
);
   initial begin
      {aw_o, awv_o, wd_o, wv_o, bp_o, ar_o, arv_o, rp_o} = '0;
   end

   // Holds each channel until its own ready edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge clk_i);
      aw_o  <= a;
      wd_o  <= d;
      awv_o <= 1'b1;
      wv_o  <= 1'b1;
      bp_o  <= 1'b1;
      do begin
         @(posedge clk_i);
         if (awr_i) awv_o <= 1'b0;
         if (wr_i) wv_o <= 1'b0;
      end while (!bv_i);
      r = br_i;
      bp_o <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk_i);
      ar_o  <= a;
      arv_o <= 1'b1;
      rp_o  <= 1'b1;
      do begin
         @(posedge clk_i);
         if (arr_i) arv_o <= 1'b0;
      end while (!rv_i);
      d = rd_i;
      r = rr_i;
      rp_o <= 1'b0;
   endtask : rd
endmodule : alr_host

// ===== tb/alr_recovery_test.sv
`timescale 1ns/100ps
module alr_recovery_test
   import alr_pkg::*;
;
   logic               clk_i, nrst_i, tick, busy, attp, ge_rst, pk, imp, lim;
   logic [9:0]         amt;
   logic [2:0]         lth;
   logic [7:0]         aw, ar, rb;
   logic               awv, awr, wv, wrdy, bv, bp, arv, arr, rv, rp, recov, psel, mute, eqb;
   logic [31:0]        wd, rdat, d;
   logic [1:0]         br, rr, r;
   logic signed [17:0] gain;
   int                 num_errors = 0;
   int                 tests_run = 0;

   alr_host i_host (.clk_i(clk_i), .aw_o(aw), .awv_o(awv), .awr_i(awr), .wd_o(wd), .wv_o(wv),
      .wr_i(wrdy), .br_i(br), .bv_i(bv), .bp_o(bp), .ar_o(ar), .arv_o(arv), .arr_i(arr),
      .rd_i(rdat), .rr_i(rr), .rv_i(rv), .rp_o(rp));

   alr_recovery i_dut (.clk_i(clk_i), .nrst_i(nrst_i), .s_axi_awaddr_i(aw),
      .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hf),
      .s_axi_wvalid_i(wv), .s_axi_wready_o(wrdy), .s_axi_bresp_o(br), .s_axi_bvalid_o(bv),
      .s_axi_bready_i(bp), .s_axi_araddr_i(ar), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
      .s_axi_rdata_o(rdat), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv), .s_axi_rready_i(rp),
      .fs_tick_i(tick), .limiter_busy_i(busy), .att_pulse_i(attp), .att_amt_i(amt),
      .out_ge_reset_i(ge_rst), .out_ge_limit_i(lim), .peak_hi_i(pk), .impulse_i(imp),
      .working_gain_o(gain), .gain_mute_o(mute), .gain_readback_o(rb), .recovering_o(recov),
      .path_select_o(psel), .limiter_threshold_sel_o(lth), .level_eq_bypass_o(eqb));

   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   // One-cycle strobes with a gap, then let gain and readback settle
   task automatic ticks(input int n);
      repeat (n) begin
         @(posedge clk_i);
         tick <= 1'b1;
         @(posedge clk_i);
         tick <= 1'b0;
      end
      repeat (2) @(posedge clk_i);
      #1;
   endtask : ticks

   task automatic limit_20();
      @(posedge clk_i);
      busy <= 1'b1;
      attp <= 1'b1;
      @(posedge clk_i);
      attp <= 1'b0;
      @(posedge clk_i);
      busy <= 1'b0;
      repeat (2) @(posedge clk_i);
      #1;
   endtask : limit_20

   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : end_sim

   initial begin
      {nrst_i, tick, busy, attp, ge_rst, pk, imp, lim} <= '0;
      amt <= 10'h014;
      repeat (12) @(posedge clk_i);
      nrst_i <= 1'b1;
      i_host.rd(ALR_OFS_CTRL, d, r);
      chk(d, ALR_RST_CTRL);
      i_host.rd(ALR_OFS_TIMING, d, r);
      chk(d, 32'h0000_0000);
      i_host.rd(ALR_OFS_REF, d, r);
      chk(d, 32'h0000_28e1);
      i_host.rd(8'h10, d, r);
      chk({d[29:0], r}, {30'h0, ALR_RESP_SLVERR});
      $display("register reset test done");
      i_host.wr(ALR_OFS_REF, 32'h0000_2891, r);
      i_host.wr(ALR_OFS_CTRL, 32'h0000_0003, r);
      limit_20();
      chk(32'(gain), 32'hffff_ffec);
      chk(rb, 8'h9e);
      ticks(127);
      chk(recov, 1'b0);
      ticks(1);
      chk(recov, 1'b1);
      ticks(1);
      chk(32'(gain), 32'hffff_fff0);
      ticks(5);
      chk({rb, 24'(gain)}, {8'ha0, 24'h0});
      $display("recovery test done");
      limit_20();
      ticks(128);
      @(posedge clk_i) ge_rst <= 1'b1;
      ticks(1);
      chk(recov, 1'b0);
      @(posedge clk_i) ge_rst <= 1'b0;
      ticks(127);
      chk(recov, 1'b0);
      ticks(1);
      chk(recov, 1'b1);
      // Output at limiter level is the limiter's job, recovery goes on
      @(posedge clk_i) {ge_rst, lim} <= 2'b11;
      ticks(1);
      chk(recov, 1'b1);
      @(posedge clk_i) {ge_rst, lim} <= 2'b00;
      $display("wait timer test done");
      i_host.wr(ALR_OFS_CTRL, 32'h0000_0001, r);
      i_host.wr(ALR_OFS_TIMING, 32'h0000_6031, r);
      i_host.wr(ALR_OFS_CTRL, 32'h0000_0003, r);
      limit_20();
      ticks(255);
      chk(recov, 1'b0);
      ticks(3);
      chk(32'(gain), 32'hffff_ffed);
      $display("slow step test done");
      @(posedge clk_i) pk <= 1'b1;
      ticks(4);
      chk(32'(gain), 32'hffff_ffee);
      @(posedge clk_i) pk <= 1'b0;
      @(posedge clk_i) imp <= 1'b1;
      @(posedge clk_i) imp <= 1'b0;
      ticks(2);
      chk(32'(gain), 32'hffff_fff4);
      i_host.rd(ALR_OFS_STAT, d, r);
      chk(d, 32'h0000_069e);
      ticks(4);
      chk(32'(gain), 32'hffff_ffff);
      $display("peak and fast test done");
      i_host.wr(ALR_OFS_CTRL, 32'h0000_0001, r);
      i_host.wr(ALR_OFS_REF, 32'h0000_2804, r);
      i_host.wr(ALR_OFS_CTRL, 32'h0000_002b, r);
      @(posedge clk_i) imp <= 1'b1;
      @(posedge clk_i) imp <= 1'b0;
      i_host.rd(ALR_OFS_STAT, d, r);
      chk(d, 32'h0000_0100);
      chk({mute, eqb, lth}, 5'h1e);
      i_host.wr(ALR_OFS_CTRL, 32'h0000_0000, r);
      ticks(0);
      chk(32'(gain), 32'h0000_1600);
      chk(psel, 1'b0);
      $display("settings test done");
      end_sim();
   end

   initial begin
      repeat (20000) @(posedge clk_i);
      num_errors++;
      end_sim();
   end
endmodule : alr_recovery_test
